// File: common/avsw_consts.svh
// constants of the audio/video switch register bank
//------------------------------------------------------------
// Contract
// - power-down pin low restores all register defaults
// - main power bit, default one, keeps registers
// - audio bias power bit, default off
// - video output mode bit, default sag mode
// - three source selects, audio and video fields
// - video watch channel field at 04H
// - audio watch settings at 05H, reset 40H
// - masks, level, video watch mode at 06H
// - mode zero: detector sets, status read clears
// - five open-drain outputs, one releases pin
// - status reports left, right, video found
// - writes to status address are discarded
// - interrupt pulls low on unmasked found flags
// - write to 04H resets timer, clears video flag
//------------------------------------------------------------
`ifndef AVSW_CONSTS_SVH
`define AVSW_CONSTS_SVH
`define AVSW_ADDR_POWER 4'h0
`define AVSW_ADDR_SEL1 4'h1
`define AVSW_ADDR_SEL2 4'h2
`define AVSW_ADDR_SEL3 4'h3
`define AVSW_ADDR_VWATCH 4'h4
`define AVSW_ADDR_AWATCH 4'h5
`define AVSW_ADDR_MASKS 4'h6
`define AVSW_ADDR_ODRAIN 4'h7
`define AVSW_ADDR_STATUS 4'h8
`define AVSW_RST_POWER 8'h01
`define AVSW_RST_SEL 8'h00
`define AVSW_RST_VWATCH 8'h00
`define AVSW_RST_AWATCH 8'h40
`define AVSW_RST_MASKS 8'h02
`define AVSW_RST_ODRAIN 8'h1F
`define AVSW_MSK_POWER 8'h13
`define AVSW_MSK_SEL 8'h77
`define AVSW_MSK_VWATCH 8'h70
`define AVSW_MSK_AWATCH 8'hF7
`define AVSW_MSK_MASKS 8'hF7
`define AVSW_MSK_ODRAIN 8'h1F
`define AVSW_BIT_PW 0
`define AVSW_BIT_BIAS 1
`define AVSW_BIT_VMODE 4
`define AVSW_BIT_LMASK 4
`define AVSW_BIT_RMASK 5
`define AVSW_BIT_VMASK 6
`define AVSW_BIT_VWMODE 7
`define AVSW_BIT_LFOUND 4
`define AVSW_BIT_RFOUND 5
`define AVSW_BIT_VFOUND 6
`define AVSW_NUM_ODRAIN 5
`endif

// File: common/avsw_pkg.sv
// types of the audio/video switch register bank
package avsw_pkg;
  typedef struct packed {
    logic main_power_on;
    logic audio_bias_on;
    logic video_out_mode;
  } avsw_power_t;
  typedef struct packed {
    logic [2:0] video_source_out1;
    logic [2:0] audio_source_out1;
    logic [2:0] video_source_out2;
    logic [2:0] audio_source_out2;
    logic [2:0] video_source_out3;
    logic [2:0] audio_source_out3;
  } avsw_route_t;
  typedef struct packed {
    logic [2:0] video_watch_channel_sel;
    logic [2:0] audio_watch_channel_sel;
    logic [1:0] audio_consecutive_count;
    logic [1:0] audio_recovery_time;
    logic [2:0] audio_threshold_level;
    logic video_watch_mode;
  } avsw_watch_t;
endpackage : avsw_pkg

// File: logic/avsw_regs.sv
// register bank of the audio/video switch
`include "avsw_consts.svh"
module avsw_regs
  import avsw_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic POWERDOWN_N_PIN,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic LEFT_AUDIO_PULSE,
  input wire logic RIGHT_AUDIO_PULSE,
  input wire logic VIDEO_SYNC_PULSE,
  input wire logic VIDEO_QUALIFIED,
  output logic VIDEO_TIMER_RESET,
  output avsw_power_t POWER_CTRL,
  output avsw_route_t ROUTE_CTRL,
  output avsw_watch_t WATCH_CTRL,
  output logic [4:0] OPEN_DRAIN_OUT_BITS_O,
  output logic [4:0] OPEN_DRAIN_OUT_BITS_OE,
  output logic INT_O,
  output logic INT_OE
);
  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [7:0] power_reg, sel1_reg, sel2_reg, sel3_reg;
  logic [7:0] vwatch_reg, awatch_reg, masks_reg, odrain_reg;
  logic left_found_reg, right_found_reg, video_found_reg;
  logic timer_reset_reg;
  logic [7:0] rdata_reg;
  // fold the pin into reset; it is a level held low, taken synchronous
  wire logic clr = !POWERDOWN_N_PIN;
  wire logic wr_power = WR_STROBE && ADDR == `AVSW_ADDR_POWER;
  wire logic wr_sel1 = WR_STROBE && ADDR == `AVSW_ADDR_SEL1;
  wire logic wr_sel2 = WR_STROBE && ADDR == `AVSW_ADDR_SEL2;
  wire logic wr_sel3 = WR_STROBE && ADDR == `AVSW_ADDR_SEL3;
  wire logic wr_vwatch = WR_STROBE && ADDR == `AVSW_ADDR_VWATCH;
  wire logic wr_awatch = WR_STROBE && ADDR == `AVSW_ADDR_AWATCH;
  wire logic wr_masks = WR_STROBE && ADDR == `AVSW_ADDR_MASKS;
  wire logic wr_odrain = WR_STROBE && ADDR == `AVSW_ADDR_ODRAIN;
  // status address has no write decode at all
  wire logic rd_status = RD_STROBE && ADDR == `AVSW_ADDR_STATUS;
  wire logic vmode = masks_reg[`AVSW_BIT_VWMODE];

  // fixed-zero bits kept zero even if host breaks its side
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      power_reg <= `AVSW_RST_POWER;
      sel1_reg <= `AVSW_RST_SEL;
      sel2_reg <= `AVSW_RST_SEL;
      sel3_reg <= `AVSW_RST_SEL;
      vwatch_reg <= `AVSW_RST_VWATCH;
      awatch_reg <= `AVSW_RST_AWATCH;
      masks_reg <= `AVSW_RST_MASKS;
      odrain_reg <= `AVSW_RST_ODRAIN;
    end else if (clr) begin
      power_reg <= `AVSW_RST_POWER;
      sel1_reg <= `AVSW_RST_SEL;
      sel2_reg <= `AVSW_RST_SEL;
      sel3_reg <= `AVSW_RST_SEL;
      vwatch_reg <= `AVSW_RST_VWATCH;
      awatch_reg <= `AVSW_RST_AWATCH;
      masks_reg <= `AVSW_RST_MASKS;
      odrain_reg <= `AVSW_RST_ODRAIN;
    end else begin
      if (wr_power) power_reg <= WDATA & `AVSW_MSK_POWER;
      if (wr_sel1) sel1_reg <= WDATA & `AVSW_MSK_SEL;
      if (wr_sel2) sel2_reg <= WDATA & `AVSW_MSK_SEL;
      if (wr_sel3) sel3_reg <= WDATA & `AVSW_MSK_SEL;
      if (wr_vwatch) vwatch_reg <= WDATA & `AVSW_MSK_VWATCH;
      if (wr_awatch) awatch_reg <= WDATA & `AVSW_MSK_AWATCH;
      if (wr_masks) masks_reg <= WDATA & `AVSW_MSK_MASKS;
      if (wr_odrain) odrain_reg <= WDATA & `AVSW_MSK_ODRAIN;
    end
  end

  //------------------------------------------------------------
  // found flags
  //------------------------------------------------------------
  // a pulse in the read cycle wins over the read clear
  wire logic left_next = LEFT_AUDIO_PULSE ||
    (left_found_reg && !rd_status);
  wire logic right_next = RIGHT_AUDIO_PULSE ||
    (right_found_reg && !rd_status);
  wire logic video_next = vmode ? VIDEO_QUALIFIED :
    (VIDEO_SYNC_PULSE || (video_found_reg && !rd_status));

  // main power off freezes detection but keeps register contents
  wire logic active = power_reg[`AVSW_BIT_PW];

  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      left_found_reg <= 1'b0;
      right_found_reg <= 1'b0;
      video_found_reg <= 1'b0;
      timer_reset_reg <= 1'b0;
    end else if (clr) begin
      left_found_reg <= 1'b0;
      right_found_reg <= 1'b0;
      video_found_reg <= 1'b0;
      timer_reset_reg <= 1'b1;
    end else begin
      timer_reset_reg <= wr_vwatch;
      if (active) begin
        left_found_reg <= left_next;
        right_found_reg <= right_next;
      end
      if (wr_vwatch) video_found_reg <= 1'b0;
      else if (active) video_found_reg <= video_next;
    end
  end

  //------------------------------------------------------------
  // read data
  //------------------------------------------------------------
  logic [7:0] status_word;
  logic [7:0] rd_mux;
  always_comb begin
    status_word = 8'h00;
    status_word[`AVSW_BIT_LFOUND] = left_found_reg;
    status_word[`AVSW_BIT_RFOUND] = right_found_reg;
    status_word[`AVSW_BIT_VFOUND] = video_found_reg;
  end
  // unmapped addresses read zero; host writes stay below 09H, host reads do not
  always_comb begin
    unique case (ADDR)
      `AVSW_ADDR_POWER: rd_mux = power_reg;
      `AVSW_ADDR_SEL1: rd_mux = sel1_reg;
      `AVSW_ADDR_SEL2: rd_mux = sel2_reg;
      `AVSW_ADDR_SEL3: rd_mux = sel3_reg;
      `AVSW_ADDR_VWATCH: rd_mux = vwatch_reg;
      `AVSW_ADDR_AWATCH: rd_mux = awatch_reg;
      `AVSW_ADDR_MASKS: rd_mux = masks_reg;
      `AVSW_ADDR_ODRAIN: rd_mux = odrain_reg;
      `AVSW_ADDR_STATUS: rd_mux = status_word;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) rdata_reg <= 8'h00;
    else if (RD_STROBE) rdata_reg <= rd_mux;
  end
  assign RDATA = rdata_reg;

  //------------------------------------------------------------
  // outputs to analog sections and pins
  //------------------------------------------------------------
  assign POWER_CTRL.main_power_on = power_reg[`AVSW_BIT_PW];
  assign POWER_CTRL.audio_bias_on = power_reg[`AVSW_BIT_BIAS];
  assign POWER_CTRL.video_out_mode = power_reg[`AVSW_BIT_VMODE];
  assign ROUTE_CTRL = {sel1_reg[6:4], sel1_reg[2:0], sel2_reg[6:4],
    sel2_reg[2:0], sel3_reg[6:4], sel3_reg[2:0]};
  assign WATCH_CTRL = {vwatch_reg[6:4], awatch_reg[2:0], awatch_reg[5:4],
    awatch_reg[7:6], masks_reg[2:0], vmode};
  assign VIDEO_TIMER_RESET = timer_reset_reg;
  // open drain: only ever drive low
  assign OPEN_DRAIN_OUT_BITS_O = 5'h00;
  assign OPEN_DRAIN_OUT_BITS_OE = ~odrain_reg[4:0];
  // video mask does not touch the flag itself, only the interrupt
  wire logic int_src =
    (left_found_reg && !masks_reg[`AVSW_BIT_LMASK]) ||
    (right_found_reg && !masks_reg[`AVSW_BIT_RMASK]) ||
    (video_found_reg && !masks_reg[`AVSW_BIT_VMASK]);
  assign INT_O = 1'b0;
  assign INT_OE = int_src;
endmodule : avsw_regs

// File: verification/avsw_props.sv
// assertion checker of the audio/video switch register bank
module avsw_props
  import avsw_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic POWERDOWN_N_PIN,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  input wire logic VIDEO_TIMER_RESET,
  input wire avsw_power_t POWER_CTRL,
  input wire avsw_route_t ROUTE_CTRL,
  input wire logic [4:0] OPEN_DRAIN_OUT_BITS_O,
  input wire logic [4:0] OPEN_DRAIN_OUT_BITS_OE,
  input wire logic INT_O,
  input wire logic INT_OE
);
  logic [7:0] wd_q;
  logic [3:0] ra_q;
  logic rd_q;
  wire powerdown_n_pin = POWERDOWN_N_PIN;
  wire wr = WR_STROBE && powerdown_n_pin;
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      {wd_q, ra_q, rd_q} <= '0;
    end else begin
      {wd_q, ra_q, rd_q} <= {WDATA, ADDR, RD_STROBE && powerdown_n_pin};
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_pdn_defaults: assert property (!powerdown_n_pin |=> POWER_CTRL == 3'b100 &&
    OPEN_DRAIN_OUT_BITS_OE == 5'h00 && !INT_OE) else $error("pdn defaults");
  a_power_write: assert property (wr && ADDR == 4'h0 |=>
    POWER_CTRL == {wd_q[0], wd_q[1], wd_q[4]}) else $error("power bits");
  a_route_write: assert property (wr && ADDR == 4'h1 |=>
    ROUTE_CTRL[17:12] == {wd_q[6:4], wd_q[2:0]}) else $error("route1");
  a_odrain_write: assert property (wr && ADDR == 4'h7 |=>
    OPEN_DRAIN_OUT_BITS_OE == ~wd_q[4:0]) else $error("od enables");
  a_pins_low: assert property (OPEN_DRAIN_OUT_BITS_O == 5'h00 && !INT_O)
    else $error("pin level");
  a_timer_pulse: assert property (wr && ADDR == 4'h4 |=> VIDEO_TIMER_RESET)
    else $error("timer reset");
  a_mask_all: assert property (wr && ADDR == 4'h6 && WDATA[6:4] == 3'h7
    |=> !INT_OE) else $error("int mask");
  a_status_nowr: assert property (wr && ADDR == 4'h8 |=> $stable(POWER_CTRL)
    && $stable(ROUTE_CTRL)) else $error("status write");
  a_status_bits: assert property (rd_q && ra_q == 4'h8 |->
    (RDATA & 8'h8F) == 8'h00) else $error("status fixed bits");
  a_unmapped_zero: assert property (rd_q && ra_q > 4'h8 |-> RDATA == 8'h00)
    else $error("unmapped read");
  a_rdata_hold: assert property (!rd_q && powerdown_n_pin && $past(powerdown_n_pin) |-> $stable(RDATA))
    else $error("rdata hold");
  c_status_read: cover property (rd_q && ra_q == 4'h8 && RDATA != 8'h00);
  c_int_low: cover property (INT_OE);
  c_timer: cover property (wr && ADDR == 4'h4);
endmodule : avsw_props
bind avsw_regs avsw_props avsw_props_i (.MCLK, .RESET, .POWERDOWN_N_PIN,
  .WR_STROBE, .RD_STROBE, .ADDR, .WDATA, .RDATA, .VIDEO_TIMER_RESET,
  .POWER_CTRL, .ROUTE_CTRL, .OPEN_DRAIN_OUT_BITS_O, .OPEN_DRAIN_OUT_BITS_OE,
  .INT_O, .INT_OE);

// File: verification/avsw_host.sv
// host controller model driving the register strobes
module avsw_host (
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output logic wr,
  output logic rd,
  output logic [3:0] addr,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wr, rd, addr, wdata} = '0;
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    if (a > 4'h8) return;
    @(negedge mclk);
    {wr, addr, wdata} = {1'b1, a, d}; // callers keep fixed bits zero
    @(negedge mclk);
    wr = 1'b0;
    wdata = ~d; // released bus must not look valid
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    {rd, addr} = {1'b1, a};
    @(negedge mclk);
    rd = 1'b0;
    d = rdata;
  endtask : rd_reg
endmodule : avsw_host

// File: verification/tb.sv
// self-checking bench of the audio/video switch register bank
module tb import avsw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset = 1, powerdown_n_pin = 1, lp = 0, rp = 0, vp = 0, vq = 0;
  logic wr, rd, vtr, int_o, int_oe;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [4:0] od_o, od_oe;
  avsw_power_t pwr;
  avsw_route_t route;
  avsw_watch_t watch;
  int error_cnt = 0, checks_done = 0;
  logic [7:0] dflt [9] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h02,
    8'h1F, 8'h00};
  avsw_host avsw_host_i (.mclk(mclk), .rdata(rdata), .wr(wr), .rd(rd),
    .addr(addr), .wdata(wdata));
  avsw_regs avsw_regs_i (.MCLK(mclk), .RESET(reset), .POWERDOWN_N_PIN(powerdown_n_pin),
    .WR_STROBE(wr), .RD_STROBE(rd), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
    .LEFT_AUDIO_PULSE(lp), .RIGHT_AUDIO_PULSE(rp), .VIDEO_SYNC_PULSE(vp),
    .VIDEO_QUALIFIED(vq), .VIDEO_TIMER_RESET(vtr), .POWER_CTRL(pwr),
    .ROUTE_CTRL(route), .WATCH_CTRL(watch), .OPEN_DRAIN_OUT_BITS_O(od_o),
    .OPEN_DRAIN_OUT_BITS_OE(od_oe), .INT_O(int_o), .INT_OE(int_oe));
  always #12.5 mclk = ~mclk;
  task automatic chk(input string n, input logic [7:0] e, s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    avsw_host_i.rd_reg(a, d);
    chk("rdata", e, d);
  endtask : rdc
  task automatic pulse(input logic [2:0] p);
    @(negedge mclk);
    {vp, rp, lp} = p;
    @(negedge mclk);
    {vp, rp, lp} = 3'h0;
  endtask : pulse
  task automatic end_sim();
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  initial begin
    #(25 * 3000);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    for (int i = 0; i < 9; i++) rdc(i[3:0], dflt[i]);
    avsw_host_i.wr_reg(4'h7, 8'h1E);
    chk("od_oe", 8'h01, {3'h0, od_oe});
    avsw_host_i.wr_reg(4'h0, 8'h13);
    chk("power", 8'h07, {5'h00, pwr});
    avsw_host_i.wr_reg(4'h1, 8'h75);
    chk("route", 8'h3D, {2'h0, route[17:12]});
    avsw_host_i.wr_reg(4'h5, 8'hB6);
    rdc(4'h5, 8'hB6);
    chk("watch", 8'h6E, {1'b0, watch[10:4]});
    avsw_host_i.wr_reg(4'h8, 8'h70);
    rdc(4'h8, 8'h00);
    pulse(3'h7);
    chk("int", 8'h01, {7'h00, int_oe});
    rdc(4'h8, 8'h70);
    rdc(4'h8, 8'h00);
    chk("int", 8'h00, {7'h00, int_oe});
    avsw_host_i.wr_reg(4'h6, 8'h72);
    pulse(3'h7);
    chk("int", 8'h00, {7'h00, int_oe});
    rdc(4'h8, 8'h70);
    pulse(3'h4);
    avsw_host_i.wr_reg(4'h4, 8'h50);
    chk("timer", 8'h01, {7'h00, vtr});
    chk("vdsel", 8'h05, {5'h00, watch[13:11]});
    rdc(4'h8, 8'h00);
    avsw_host_i.wr_reg(4'h6, 8'h82);
    chk("level", 8'h05, {4'h0, watch[3:0]});
    vq = 1'b1;
    rdc(4'h8, 8'h40);
    rdc(4'h8, 8'h40);
    vq = 1'b0;
    @(negedge mclk);
    rdc(4'h8, 8'h00);
    rdc(4'hA, 8'h00);
    avsw_host_i.wr_reg(4'h0, 8'h00);
    pulse(3'h3);
    rdc(4'h8, 8'h00);
    rdc(4'h0, 8'h00);
    powerdown_n_pin = 1'b0;
    repeat (2) @(negedge mclk);
    powerdown_n_pin = 1'b1;
    rdc(4'h0, 8'h01);
    rdc(4'h6, 8'h02);
    chk("od_oe", 8'h00, {3'h0, od_oe});
    end_sim();
  end
endmodule : tb
